/* hw/dso_status_out.sv */
// Drive status-output logic: flag evaluation, terminal routing, register port
`timescale 1ns/1ps

// Overview of operation
// - Auto-reset flag follows the automatic fault-reset sequence being under way.
// - Communication output follows the software-written bit only, not drive state.
// - Heat-sink warning sets above trip minus 5 C, clears at trip minus 8 C.
// - Service-life flag set when any capacitor or the fan reaches end of life.
// - Reference-loss flag follows analog frequency input reference-loss state.
// - Low-frequency flag when at or below starting frequency or DC braking.
// - Overload-prevention flag follows control, each pulse held at least 100 ms.
// - Current flags set when current stays above level longer than timer; 100 ms min.
// - Current flags clear only when current falls below 90% of their level.
// - Both current flags can be routed to different terminals independently.
// - First current level serves both current flag 1 and overload pre-warning.
// - Process loop alarm on enabled absolute-value or deviation alarm.
// - Motor-2 flag follows the motor-select digital input command.
// - Thermistor flag when mode is 2 and motor temperature reaches trip level.
// - Brake command follows the brake-control decision.
// - C1 break flag when C1 is feedback input and its wire breaks.
// - Encoder fault flag on any speed-encoder error.
// - Position overflow flag when count leaves plus or minus 9,999,999.
// - Any-alarm flag whenever a protective function trips into alarm state.
// - Arrival flag inside reference plus/minus hysteresis; delayed flag after delay.
// - Level-detect flag above level, cleared below level minus hysteresis.
// - Overload pre-warning when output current exceeds first current level.
// - Each terminal selectable in normal or negative polarity.
module dso_status_out #(
  parameter int TICK_DIV = dso_pkg::TICK_CYCLES
) (
  input  wire logic                            clk_in,
  input  wire logic                            rst_in,
  input  wire logic [7:0]                      addr_in,
  input  wire logic [31:0]                     wdata_in,
  input  wire logic                            wr_in,
  input  wire logic                            rd_in,
  output logic      [31:0]                     rdata_out,
  input  wire dso_pkg::dso_meas_t              meas_in,
  input  wire dso_pkg::dso_cond_t              cond_in,
  input  wire logic                            motor_select_input_in,
  output logic      [dso_pkg::NUM_TERMS-1:0]   term_out,
  output dso_pkg::dso_flags_t                  flags_out
);

  // Configuration registers
  logic [4:0]                         ctrl;
  logic [15:0]                        arrival_hysteresis;
  logic [15:0]                        arrival_delay_time;
  logic [15:0]                        freq_detect_level;
  logic [15:0]                        freq_detect_hysteresis;
  logic [15:0]                        cur_level [2];
  logic [15:0]                        cur_timer [2];
  logic [7:0]                         thermistor_trip_level;
  logic [23:0]                        term_sel;
  logic [1:0]                         thermistor_mode;

  dso_pkg::dso_flags_t                flags;
  logic [31:0]                        tick_cnt;
  logic                               tick;
  logic                               m2_sync1;
  logic                               m2_sync2;
  logic [15:0]                        arr_cnt;
  logic [15:0]                        olp_width;
  logic [1:0]                         cur_flag;
  logic [16:0]                        freq_diff;
  logic [16:0]                        freq_abs;
  logic                               in_arrival;

  assign thermistor_mode = ctrl[dso_pkg::CTRL_THM_LSB +: 2];

  // Register writes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl                   <= dso_pkg::RST_CTRL;
      arrival_hysteresis     <= dso_pkg::RST_ARR_HYST;
      arrival_delay_time     <= dso_pkg::RST_ARR_DELAY;
      freq_detect_level      <= dso_pkg::RST_FDT_LEVEL;
      freq_detect_hysteresis <= dso_pkg::RST_FDT_HYST;
      cur_level[0]           <= dso_pkg::RST_CUR_LEVEL;
      cur_level[1]           <= dso_pkg::RST_CUR_LEVEL;
      cur_timer[0]           <= dso_pkg::RST_CUR_TIMER;
      cur_timer[1]           <= dso_pkg::RST_CUR_TIMER;
      thermistor_trip_level  <= dso_pkg::RST_THM_LEVEL;
      term_sel               <= dso_pkg::RST_TERM_SEL;
    end else if (wr_in) begin
      case (addr_in)
        dso_pkg::REG_CTRL:        ctrl <= wdata_in[4:0];
        dso_pkg::REG_ARR_HYST:    arrival_hysteresis <= wdata_in[15:0];
        dso_pkg::REG_ARR_DELAY:   arrival_delay_time <= wdata_in[15:0];
        dso_pkg::REG_FDT_LEVEL:   freq_detect_level <= wdata_in[15:0];
        dso_pkg::REG_FDT_HYST:    freq_detect_hysteresis <= wdata_in[15:0];
        dso_pkg::REG_CUR_LEVEL_1: cur_level[0] <= wdata_in[15:0];
        dso_pkg::REG_CUR_TIMER_1: cur_timer[0] <= wdata_in[15:0];
        dso_pkg::REG_CUR_LEVEL_2: cur_level[1] <= wdata_in[15:0];
        dso_pkg::REG_CUR_TIMER_2: cur_timer[1] <= wdata_in[15:0];
        dso_pkg::REG_THM_LEVEL:   thermistor_trip_level <= wdata_in[7:0];
        dso_pkg::REG_TERM_SEL:    term_sel <= wdata_in[23:0];
        default: ;
      endcase
    end
  end

  // Register reads: data stand in the cycle after the strobe only
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      case (addr_in)
        dso_pkg::REG_CTRL:        rdata_out <= {27'h0000000, ctrl};
        dso_pkg::REG_ARR_HYST:    rdata_out <= {16'h0000, arrival_hysteresis};
        dso_pkg::REG_ARR_DELAY:   rdata_out <= {16'h0000, arrival_delay_time};
        dso_pkg::REG_FDT_LEVEL:   rdata_out <= {16'h0000, freq_detect_level};
        dso_pkg::REG_FDT_HYST:    rdata_out <= {16'h0000, freq_detect_hysteresis};
        dso_pkg::REG_CUR_LEVEL_1: rdata_out <= {16'h0000, cur_level[0]};
        dso_pkg::REG_CUR_TIMER_1: rdata_out <= {16'h0000, cur_timer[0]};
        dso_pkg::REG_CUR_LEVEL_2: rdata_out <= {16'h0000, cur_level[1]};
        dso_pkg::REG_CUR_TIMER_2: rdata_out <= {16'h0000, cur_timer[1]};
        dso_pkg::REG_THM_LEVEL:   rdata_out <= {24'h000000, thermistor_trip_level};
        dso_pkg::REG_TERM_SEL:    rdata_out <= {8'h00, term_sel};
        dso_pkg::REG_STATUS:      rdata_out <= 32'(flags);
        default:                  rdata_out <= 32'h00000000;
      endcase
    end else begin
      rdata_out <= 32'h00000000;
    end
  end

  // Millisecond tick
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt <= 32'h00000000;
      tick     <= 1'b0;
    end else if (tick_cnt >= 32'(TICK_DIV - 1)) begin
      tick_cnt <= 32'h00000000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
      tick     <= 1'b0;
    end
  end

  // Motor-select comes from a terminal pin, so it is synchronised first
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      m2_sync1 <= 1'b0;
      m2_sync2 <= 1'b0;
    end else begin
      m2_sync1 <= motor_select_input_in;
      m2_sync2 <= m2_sync1;
    end
  end

  // Plain condition flags, sampled once per tick
  // A condition shorter than one tick may be missed
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags.auto_reset_active       <= 1'b0;
      flags.service_life            <= 1'b0;
      flags.reference_loss          <= 1'b0;
      flags.output_on_low_freq      <= 1'b0;
      flags.process_loop_alarm      <= 1'b0;
      flags.motor2_selected         <= 1'b0;
      flags.motor_thermistor_hot    <= 1'b0;
      flags.brake_command           <= 1'b0;
      flags.c1_input_break          <= 1'b0;
      flags.encoder_fault           <= 1'b0;
      flags.position_count_overflow <= 1'b0;
      flags.any_alarm               <= 1'b0;
      flags.motor_overload_prewarn  <= 1'b0;
    end else if (tick) begin
      flags.auto_reset_active  <= cond_in.auto_reset_busy;
      flags.service_life       <= cond_in.cap_life_end | cond_in.fan_life_end;
      flags.reference_loss     <= cond_in.analog_ref_lost;
      flags.output_on_low_freq <= cond_in.at_or_below_start | cond_in.dc_brake_on;
      flags.process_loop_alarm <=
        (ctrl[dso_pkg::CTRL_PID_ABS_BIT] & cond_in.pid_abs_alarm) |
        (ctrl[dso_pkg::CTRL_PID_DEV_BIT] & cond_in.pid_dev_alarm);
      flags.motor2_selected    <= m2_sync2;
      flags.motor_thermistor_hot <= (thermistor_mode == dso_pkg::THM_MODE_ON) &&
                                    (meas_in.motor_temp >= thermistor_trip_level);
      flags.brake_command      <= cond_in.brake_release;
      flags.c1_input_break     <= cond_in.c1_is_feedback & cond_in.c1_wire_broken;
      flags.encoder_fault      <= cond_in.encoder_error;
      flags.position_count_overflow <= (meas_in.position > dso_pkg::POS_LIMIT) ||
                                       (meas_in.position < -dso_pkg::POS_LIMIT);
      flags.any_alarm          <= cond_in.alarm_mode;
      // Shares the first current level with current flag 1
      flags.motor_overload_prewarn <= meas_in.out_current > cur_level[0];
    end
  end

  // Communication output is software-owned and bypasses the tick
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags.general_comm_output <= 1'b0;
    end else begin
      flags.general_comm_output <= ctrl[dso_pkg::CTRL_COMM_BIT];
    end
  end

  // Heat-sink early warning with 3 C of hysteresis
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags.heatsink_warn <= 1'b0;
    end else if (tick) begin
      if ({1'b0, meas_in.heatsink_temp} + dso_pkg::HEAT_SET_MARGIN_C >
          {1'b0, meas_in.heatsink_trip}) begin
        flags.heatsink_warn <= 1'b1;
      end else if ({1'b0, meas_in.heatsink_temp} + dso_pkg::HEAT_CLR_MARGIN_C <=
                   {1'b0, meas_in.heatsink_trip}) begin
        flags.heatsink_warn <= 1'b0;
      end
    end
  end

  // Frequency arrival and delayed arrival
  // Unsigned inputs: the difference needs a sign bit
  assign freq_diff  = {1'b0, meas_in.out_freq} - {1'b0, meas_in.ref_freq};
  assign freq_abs   = freq_diff[16] ? (17'h00000 - freq_diff) : freq_diff;
  assign in_arrival = freq_abs <= {1'b0, arrival_hysteresis};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags.freq_arrived         <= 1'b0;
      flags.freq_arrived_delayed <= 1'b0;
      arr_cnt                    <= 16'h0000;
    end else if (tick) begin
      flags.freq_arrived <= in_arrival;
      if (!in_arrival) begin
        arr_cnt                    <= 16'h0000;
        flags.freq_arrived_delayed <= 1'b0;
      end else if (arr_cnt >= arrival_delay_time) begin
        flags.freq_arrived_delayed <= 1'b1;
      end else begin
        arr_cnt <= arr_cnt + 16'h0001;
      end
    end
  end

  // Frequency level detection; hysteresis sits below the level
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags.freq_level_detect <= 1'b0;
    end else if (tick) begin
      if (meas_in.out_freq > freq_detect_level) begin
        flags.freq_level_detect <= 1'b1;
      end else if ({1'b0, meas_in.out_freq} + {1'b0, freq_detect_hysteresis} <
                   {1'b0, freq_detect_level}) begin
        flags.freq_level_detect <= 1'b0;
      end
    end
  end

  // Overload prevention, stretched to the minimum on-time
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags.overload_prevent_active <= 1'b0;
      olp_width                     <= 16'h0000;
    end else if (tick) begin
      if (cond_in.overload_prevent_on) begin
        flags.overload_prevent_active <= 1'b1;
        olp_width                     <= 16'h0001;
      end else if (flags.overload_prevent_active) begin
        if (olp_width >= dso_pkg::MIN_ON_TICKS) begin
          flags.overload_prevent_active <= 1'b0;
        end else begin
          olp_width <= olp_width + 16'h0001;
        end
      end
    end
  end

  // Current detection channels; channel 0 uses the first level
  generate
    for (genvar c = 0; c < 2; c++) begin : g_cur
      logic [15:0] over_cnt;
      logic [15:0] width_cnt;
      logic        above;
      logic        below_off;
      assign above     = meas_in.out_current > cur_level[c];
      // Off threshold of 90% compared without a divider
      assign below_off = (20'(meas_in.out_current) * 20'(dso_pkg::CUR_OFF_DEN)) <
                         (20'(cur_level[c]) * 20'(dso_pkg::CUR_OFF_NUM));
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          cur_flag[c] <= 1'b0;
          over_cnt    <= 16'h0000;
          width_cnt   <= 16'h0000;
        end else if (tick) begin
          // Saturates so a long overload cannot wrap the timer
          if (!above) begin
            over_cnt <= 16'h0000;
          end else if (over_cnt != 16'hffff) begin
            over_cnt <= over_cnt + 16'h0001;
          end
          if (!cur_flag[c]) begin
            if (above && (over_cnt >= cur_timer[c])) begin
              cur_flag[c] <= 1'b1;
              width_cnt   <= 16'h0001;
            end
          end else if (width_cnt < dso_pkg::MIN_ON_TICKS) begin
            width_cnt <= width_cnt + 16'h0001;
          end else if (below_off) begin
            cur_flag[c] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_comb begin
    flags.current_detect_1 = cur_flag[0];
    flags.current_detect_2 = cur_flag[1];
  end

  // Map a selection code onto its flag
  function automatic logic flag_by_code(input logic [6:0] code,
                                        input dso_pkg::dso_flags_t f);
    case (code)
      dso_pkg::SEL_FAR:     flag_by_code = f.freq_arrived;
      dso_pkg::SEL_FDT:     flag_by_code = f.freq_level_detect;
      dso_pkg::SEL_OL:      flag_by_code = f.motor_overload_prewarn;
      dso_pkg::SEL_FREQ_ARRIVED_DELAYED:    flag_by_code = f.freq_arrived_delayed;
      dso_pkg::SEL_RESET:   flag_by_code = f.auto_reset_active;
      dso_pkg::SEL_COMM:    flag_by_code = f.general_comm_output;
      dso_pkg::SEL_HEAT:    flag_by_code = f.heatsink_warn;
      dso_pkg::SEL_LIFE:    flag_by_code = f.service_life;
      dso_pkg::SEL_REFLOSS: flag_by_code = f.reference_loss;
      dso_pkg::SEL_LOWF:    flag_by_code = f.output_on_low_freq;
      dso_pkg::SEL_OLP:     flag_by_code = f.overload_prevent_active;
      dso_pkg::SEL_ID1:     flag_by_code = f.current_detect_1;
      dso_pkg::SEL_ID2:     flag_by_code = f.current_detect_2;
      dso_pkg::SEL_PID:     flag_by_code = f.process_loop_alarm;
      dso_pkg::SEL_M2:      flag_by_code = f.motor2_selected;
      dso_pkg::SEL_THM:     flag_by_code = f.motor_thermistor_hot;
      dso_pkg::SEL_BRAKE:   flag_by_code = f.brake_command;
      dso_pkg::SEL_C1:      flag_by_code = f.c1_input_break;
      dso_pkg::SEL_ENC:     flag_by_code = f.encoder_fault;
      dso_pkg::SEL_POF:     flag_by_code = f.position_count_overflow;
      dso_pkg::SEL_ALM:     flag_by_code = f.any_alarm;
      default:              flag_by_code = 1'b0;
    endcase
  endfunction

  // Terminal routing; any flag may go to any terminal, so the current flags stay independent
  // In reset every terminal is low, whatever its polarity
  generate
    for (genvar t = 0; t < dso_pkg::NUM_TERMS; t++) begin : g_term
      logic [7:0] sel;
      assign sel = term_sel[t*dso_pkg::TERM_SEL_W +: dso_pkg::TERM_SEL_W];
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          term_out[t] <= 1'b0;
        end else begin
          term_out[t] <= flag_by_code(sel[6:0], flags) ^ sel[dso_pkg::TERM_NEG_BIT];
        end
      end
    end
  endgenerate

  // Flag snapshot for downstream logic
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_out <= '0;
    end else begin
      flags_out <= flags;
    end
  end

endmodule

/* hw/dso_pkg.sv */
// Package: constants and carrier types for the drive status-output block
package dso_pkg;

  // Register byte offsets (32-bit words)
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_ARR_HYST    = 8'h04;
  localparam logic [7:0] REG_ARR_DELAY   = 8'h08;
  localparam logic [7:0] REG_FDT_LEVEL   = 8'h0c;
  localparam logic [7:0] REG_FDT_HYST    = 8'h10;
  localparam logic [7:0] REG_CUR_LEVEL_1 = 8'h14;
  localparam logic [7:0] REG_CUR_TIMER_1 = 8'h18;
  localparam logic [7:0] REG_CUR_LEVEL_2 = 8'h1c;
  localparam logic [7:0] REG_CUR_TIMER_2 = 8'h20;
  localparam logic [7:0] REG_THM_LEVEL   = 8'h24;
  localparam logic [7:0] REG_TERM_SEL    = 8'h28;
  localparam logic [7:0] REG_STATUS      = 8'h2c;

  // Control register fields
  localparam int CTRL_COMM_BIT    = 0;
  localparam int CTRL_THM_LSB     = 1;
  localparam int CTRL_PID_ABS_BIT = 3;
  localparam int CTRL_PID_DEV_BIT = 4;

  // Terminal selection fields, one byte per terminal
  localparam int NUM_TERMS     = 3;
  localparam int TERM_SEL_W    = 8;
  localparam int TERM_NEG_BIT  = 7;

  // Reset values
  localparam logic [15:0] RST_ARR_HYST  = 16'h0019;
  localparam logic [15:0] RST_ARR_DELAY = 16'h0064;
  localparam logic [15:0] RST_FDT_LEVEL = 16'h0258;
  localparam logic [15:0] RST_FDT_HYST  = 16'h000a;
  localparam logic [15:0] RST_CUR_LEVEL = 16'h0064;
  localparam logic [15:0] RST_CUR_TIMER = 16'h000a;
  localparam logic [7:0]  RST_THM_LEVEL = 8'h64;
  localparam logic [4:0]  RST_CTRL      = 5'h00;
  localparam logic [23:0] RST_TERM_SEL  = 24'h000000;

  // Selection codes
  localparam logic [6:0] SEL_FAR     = 7'h01;
  localparam logic [6:0] SEL_FDT     = 7'h02;
  localparam logic [6:0] SEL_OL      = 7'h07;
  localparam logic [6:0] SEL_FREQ_ARRIVED_DELAYED    = 7'h15;
  localparam logic [6:0] SEL_RESET   = 7'h1a;
  localparam logic [6:0] SEL_COMM    = 7'h1b;
  localparam logic [6:0] SEL_HEAT    = 7'h1c;
  localparam logic [6:0] SEL_LIFE    = 7'h1e;
  localparam logic [6:0] SEL_REFLOSS = 7'h21;
  localparam logic [6:0] SEL_LOWF    = 7'h23;
  localparam logic [6:0] SEL_OLP     = 7'h24;
  localparam logic [6:0] SEL_ID1     = 7'h25;
  localparam logic [6:0] SEL_ID2     = 7'h26;
  localparam logic [6:0] SEL_PID     = 7'h2a;
  localparam logic [6:0] SEL_M2      = 7'h31;
  localparam logic [6:0] SEL_THM     = 7'h38;
  localparam logic [6:0] SEL_BRAKE   = 7'h39;
  localparam logic [6:0] SEL_C1      = 7'h3b;
  localparam logic [6:0] SEL_ENC     = 7'h4c;
  localparam logic [6:0] SEL_POF     = 7'h53;
  localparam logic [6:0] SEL_ALM     = 7'h63;

  localparam logic [1:0] THM_MODE_ON = 2'h2;

  // Timing
  localparam int TICK_PERIOD_US = 1000;
  localparam int CLK_RATE_MHZ   = 50;
  localparam int TICK_CYCLES    = TICK_PERIOD_US * CLK_RATE_MHZ;
  localparam int MIN_ON_MS      = 100;
  localparam logic [15:0] MIN_ON_TICKS = 16'(MIN_ON_MS * 1000 / TICK_PERIOD_US);

  // Thresholds
  localparam logic [8:0]  HEAT_SET_MARGIN_C = 9'h005;
  localparam logic [8:0]  HEAT_CLR_MARGIN_C = 9'h008;
  localparam logic signed [31:0] POS_LIMIT  = 32'sh0098967f;
  localparam logic [3:0]  CUR_OFF_NUM       = 4'h9;
  localparam logic [3:0]  CUR_OFF_DEN       = 4'ha;

  // Measured drive conditions, all from logic on the same clock
  typedef struct packed {
    logic [15:0]        out_freq;
    logic [15:0]        ref_freq;
    logic [15:0]        out_current;
    logic [7:0]         heatsink_temp;
    logic [7:0]         heatsink_trip;
    logic [7:0]         motor_temp;
    logic signed [31:0] position;
  } dso_meas_t;

  typedef struct packed {
    logic auto_reset_busy;
    logic cap_life_end;
    logic fan_life_end;
    logic analog_ref_lost;
    logic at_or_below_start;
    logic dc_brake_on;
    logic overload_prevent_on;
    logic pid_abs_alarm;
    logic pid_dev_alarm;
    logic brake_release;
    logic c1_is_feedback;
    logic c1_wire_broken;
    logic encoder_error;
    logic alarm_mode;
  } dso_cond_t;

  typedef struct packed {
    logic freq_arrived;
    logic freq_arrived_delayed;
    logic freq_level_detect;
    logic motor_overload_prewarn;
    logic auto_reset_active;
    logic general_comm_output;
    logic heatsink_warn;
    logic service_life;
    logic reference_loss;
    logic output_on_low_freq;
    logic overload_prevent_active;
    logic current_detect_1;
    logic current_detect_2;
    logic process_loop_alarm;
    logic motor2_selected;
    logic motor_thermistor_hot;
    logic brake_command;
    logic c1_input_break;
    logic encoder_fault;
    logic position_count_overflow;
    logic any_alarm;
  } dso_flags_t;

  localparam int FLAGS_W = $bits(dso_flags_t);

endpackage

/* test/dso_status_out_asserts.sv */
// Port checker for the drive status-output block
`timescale 1ns/1ps
module dso_status_out_asserts #(
  parameter int TICK_DIV = 10
) (
  input wire logic               clk_in,
  input wire logic               rst_in,
  input wire logic               wr_in,
  input wire dso_pkg::dso_cond_t  cond_in,
  input wire dso_pkg::dso_flags_t flags_out
);
  // One tick of slack: the rise may land anywhere inside the first tick
  localparam int MIN_W = 99 * TICK_DIV;
  int on_cnt, olp_cnt;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) on_cnt <= 0;
    else if (flags_out.current_detect_1) on_cnt <= on_cnt + 1;
    else on_cnt <= 0;
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) olp_cnt <= 0;
    else olp_cnt <= flags_out.overload_prevent_active ? olp_cnt + 1 : 0;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property rose_cause(logic f, logic c);
    $rose(f) |-> $past(c) || $past(c, 2) || $past(c, 3);
  endproperty
  a_reset_cause: assert property (rose_cause(flags_out.auto_reset_active,
    cond_in.auto_reset_busy)) else $error("auto-reset flag without busy");
  a_comm_write: assert property ($changed(flags_out.general_comm_output) |->
    $past(wr_in, 2) || $past(wr_in, 3) || $past(wr_in, 4)) else $error("comm moved alone");
  a_lowf_cause: assert property (rose_cause(flags_out.output_on_low_freq,
    cond_in.at_or_below_start || cond_in.dc_brake_on)) else $error("low-freq flag no cause");
  a_olp_min: assert property ($fell(flags_out.overload_prevent_active) |->
    $past(olp_cnt) >= MIN_W) else $error("overload flag too short");
  a_id_min_width: assert property ($fell(flags_out.current_detect_1) |->
    $past(on_cnt) >= MIN_W) else $error("current flag too short");
  a_prewarn_shared: assert property ($rose(flags_out.current_detect_1) |->
    flags_out.motor_overload_prewarn) else $error("prewarn off at current detect");
  a_alarm_cause: assert property (rose_cause(flags_out.any_alarm,
    cond_in.alarm_mode)) else $error("alarm flag without alarm mode");
  a_delay_after: assert property (flags_out.freq_arrived_delayed |->
    flags_out.freq_arrived) else $error("delayed arrival outside arrival");
  c_id_rise: cover property ($rose(flags_out.current_detect_1));
  c_olp_fall: cover property ($fell(flags_out.overload_prevent_active));
  c_dly_rise: cover property ($rose(flags_out.freq_arrived_delayed));
endmodule
bind dso_status_out dso_status_out_asserts #(.TICK_DIV(TICK_DIV)) u_chk (.clk_in(clk_in),
  .rst_in(rst_in), .wr_in(wr_in), .cond_in(cond_in), .flags_out(flags_out));

/* test/dso_term_reader.sv */
// Far-side equipment model: registers the terminal levels it reads
`timescale 1ns/1ps
module dso_term_reader (
  input  wire logic       clk_in,
  input  wire logic [2:0] term_in,
  output logic      [2:0] seen_out
);
  // Real inputs see the pins through their own register, one clock late
  always_ff @(posedge clk_in) begin
    seen_out <= term_in;
  end
endmodule

/* test/test_drive_status_output_logic.sv */
// Self-checking bench for the drive status-output block
`timescale 1ns/1ps
module test_drive_status_output_logic;
  localparam int TD = 10;
  logic clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, msel = 0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0, rdata_out;
  logic [2:0] term, seen;
  dso_pkg::dso_meas_t ms = '0;
  dso_pkg::dso_cond_t cd = '0;
  dso_pkg::dso_flags_t fl;
  int n_errors = 0, check_count = 0;
  logic [31:0] rv [11] = '{32'h0, 32'h19, 32'h64, 32'h258, 32'ha, 32'h64, 32'ha, 32'h64,
    32'ha, 32'h64, 32'h0};
  always #10 clk_in = ~clk_in;
  dso_status_out #(.TICK_DIV(TD)) dut_u (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .meas_in(ms),
    .cond_in(cd), .motor_select_input_in(msel), .term_out(term), .flags_out(fl));
  dso_term_reader rdr_u (.clk_in(clk_in), .term_in(term), .seen_out(seen));
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1;
    @(posedge clk_in);
    wr_in <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1;
    @(posedge clk_in);
    rd_in <= 0;
    #1 chk("rdata", rdata_out, e);
  endtask
  task tk(input int n);
    repeat (n * TD) @(posedge clk_in);
  endtask
  task report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_in);
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 0;
    for (int i = 0; i < 11; i++) rd(8'(i * 4), rv[i]);
    rd(8'h30, 32'h0);
    wr(8'h28, 32'h00269b1b);
    wr(8'h00, 32'h1);
    tk(1);
    chk("comm", {fl.general_comm_output, seen}, 32'h9);
    wr(8'h00, 32'hc);
    tk(1);
    chk("comm", {fl.general_comm_output, seen}, 32'h2);
    cd <= '1;
    msel <= 1;
    ms.motor_temp <= 8'h64;
    ms.heatsink_trip <= 8'h64;
    ms.heatsink_temp <= 8'h60;
    ms.position <= 32'sh00989680;
    tk(3);
    chk("conds", {fl.any_alarm, fl.auto_reset_active, fl.service_life, fl.reference_loss,
      fl.output_on_low_freq, fl.overload_prevent_active, fl.process_loop_alarm,
      fl.brake_command, fl.c1_input_break, fl.encoder_fault, fl.motor2_selected,
      fl.motor_thermistor_hot}, 32'hfff);
    chk("heat pos", {fl.heatsink_warn, fl.position_count_overflow}, 32'h3);
    cd <= '0;
    msel <= 0;
    ms.motor_temp <= 8'h00;
    ms.heatsink_temp <= 8'h5d;
    ms.position <= 32'sh0098967f;
    tk(3);
    chk("conds", {fl.any_alarm, fl.auto_reset_active, fl.service_life, fl.reference_loss,
      fl.output_on_low_freq, fl.overload_prevent_active, fl.process_loop_alarm,
      fl.brake_command, fl.c1_input_break, fl.encoder_fault, fl.motor2_selected,
      fl.motor_thermistor_hot}, 32'h040);
    chk("heat pos", {fl.heatsink_warn, fl.position_count_overflow}, 32'h2);
    ms.heatsink_temp <= 8'h5c;
    tk(2);
    chk("heat", fl.heatsink_warn, 32'h0);
    wr(8'h08, 32'h5);
    ms.ref_freq <= 16'h1f4;
    ms.out_freq <= 16'h2bc;
    tk(2);
    chk("freq", {fl.freq_arrived, fl.freq_arrived_delayed, fl.freq_level_detect}, 32'h1);
    ms.out_freq <= 16'h253;
    tk(2);
    chk("freq", {fl.freq_arrived, fl.freq_arrived_delayed, fl.freq_level_detect}, 32'h1);
    ms.out_freq <= 16'h1e0;
    tk(2);
    chk("freq", {fl.freq_arrived, fl.freq_arrived_delayed, fl.freq_level_detect}, 32'h4);
    tk(6);
    chk("freq", {fl.freq_arrived, fl.freq_arrived_delayed}, 32'h3);
    wr(8'h1c, 32'h12c);
    ms.out_current <= 16'hc8;
    tk(5);
    chk("cur", {fl.current_detect_1, fl.current_detect_2, fl.motor_overload_prewarn}, 32'h1);
    tk(8);
    chk("cur", {fl.current_detect_1, fl.current_detect_2, fl.motor_overload_prewarn, seen[2]},
      32'ha);
    ms.out_current <= 16'h5f;
    tk(2);
    chk("cur", {fl.current_detect_1, fl.motor_overload_prewarn}, 32'h2);
    ms.out_current <= 16'h59;
    cd.overload_prevent_on <= 1;
    tk(2);
    chk("min on", {fl.current_detect_1, fl.overload_prevent_active}, 32'h3);
    cd.overload_prevent_on <= 0;
    tk(50);
    chk("olp", fl.overload_prevent_active, 32'h1);
    tk(60);
    chk("min on", {fl.current_detect_1, fl.overload_prevent_active}, 32'h0);
    rd(8'h2c, 32'h00180000);
    rd(8'h28, 32'h00269b1b);
    rst_in <= 1;
    @(posedge clk_in);
    #1 chk("reset", fl, 32'h0);
    report_and_stop();
  end
endmodule
